/* File: inc/cable_marker_pkg.sv */
package cable_marker_pkg;

	// Clock rate of mclk
	localparam int unsigned MCLK_HZ              = 40_000_000;
	localparam int unsigned HZ_PER_KHZ           = 1000;

	// Longest boot time vconn_stable_time, in milliseconds
	localparam int unsigned VCONN_STABLE_TIME_MS = 50;

	// Longest time rounds down to whole cycles
	localparam int unsigned VCONN_STABLE_CYCLES  =
		(MCLK_HZ / HZ_PER_KHZ) * VCONN_STABLE_TIME_MS;

	// Synchroniser reset level
	localparam logic        SYNC_RESET_VAL       = 1'b0;

	// Marker connection states
	typedef enum logic [1:0] {
		CABLE_POWER_ON,
		UNASSIGNED_SOP,
		ASSIGN_SOP1,
		ASSIGN_SOP2
	} cable_state_e;

endpackage

/* File: logic/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import cable_marker_pkg::*;
#(
	parameter int unsigned WIDTH = 1
)
(
	// Clock, reset and enable
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	// Asynchronous inputs and their synchronised copies
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} sync_s;

	sync_s sy_reg;
	sync_s sy_next;

	// Two stages; only the second stage reads the first
	always_comb
	begin
		sy_next.meta = async_in;
		sy_next.sync = sy_reg.meta;
	end

	// Both stages freeze with the enable; a pin pulse that starts and ends while it is low is missed
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sy_reg <= {(2 * WIDTH){SYNC_RESET_VAL}};
		end
		else if (clk_en)
		begin
			sy_reg <= sy_next;
		end
	end

	// Logic only ever sees the settled second stage
	assign sync_out = sy_reg.sync;

endmodule
`default_nettype wire

/* File: logic/cable_marker.sv */
`timescale 1ns/1ps
`default_nettype none
module cable_marker
	import cable_marker_pkg::*;
#(
	parameter bit          ACTIVE_CABLE  = 1'b1,
	parameter bit          SOP2_SUPPORT  = 1'b1,
	parameter int unsigned STABLE_CYCLES = VCONN_STABLE_CYCLES
)
(
	// Clock, reset and enable
	input  wire logic   mclk,
	input  wire logic   rst_n,
	input  wire logic   clk_en,
	// Analog sense pins, asynchronous
	input  wire logic   vconn_local_pin,
	input  wire logic   vconn_remote_pin,
	input  wire logic   vconn_low_pin,
	input  wire logic   por_pin,
	// Events from on-chip logic, same clock
	input  wire logic   boot_done,
	input  wire logic   hard_reset_seen,
	input  wire logic   cable_reset_seen,
	// Incoming message from the PD receiver
	input  wire logic   msg_valid,
	input  wire logic   msg_to_sop1,
	input  wire logic   msg_to_sop2,
	// Message answer decision, one-cycle pulses
	output logic        msg_ack,
	output logic        msg_drop,
	// Termination and address enables
	output logic        ra_en,
	output logic        sop1_en,
	output logic        sop2_en,
	// Present state
	output var cable_state_e cable_state
);

	localparam int unsigned CNT_W = $clog2(STABLE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYCLES - 1);

	typedef struct packed {
		cable_state_e     state;
		logic [CNT_W-1:0] boot_cnt;
		logic             ra_en;
		logic             sop1_en;
		logic             sop2_en;
		logic             ack;
		logic             drop;
	} marker_s;

	marker_s st_reg;
	marker_s st_next;

	logic [3:0] pins_sync;
	logic       vconn_local;
	logic       vconn_remote;
	logic       vconn_low;
	logic       por_evt;
	logic       vconn_any;
	logic       link_reset;
	logic       drop_power;
	logic       msg_ok;

	// Pins are synchronised before any logic looks at them
	pin_sync #(
		.WIDTH    (4)
	) u_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.async_in ({por_pin, vconn_low_pin, vconn_remote_pin,
			vconn_local_pin}),
		.sync_out (pins_sync)
	);

	// Separate local and remote VCONN sense
	assign vconn_local  = pins_sync[0];
	assign vconn_remote = pins_sync[1];
	assign vconn_low    = pins_sync[2];
	assign por_evt      = pins_sync[3];

	// A passive cable only ever sees VCONN from its own plug
	assign vconn_any  = vconn_local | (ACTIVE_CABLE & vconn_remote);
	assign link_reset = hard_reset_seen | cable_reset_seen;
	assign drop_power = vconn_low | por_evt;

	// Next state and registered outputs
	always_comb
	begin
		st_next      = st_reg;
		st_next.ack  = 1'b0;
		st_next.drop = 1'b0;
		msg_ok       = 1'b0;
		case (st_reg.state)
			CABLE_POWER_ON:
			begin
				// Boot timer only runs while powered
				if (!vconn_any)
				begin
					st_next.boot_cnt = CNT_ZERO;
				end
				else if (boot_done || st_reg.boot_cnt >= CNT_LAST)
				begin
					// Timer forces the exit if boot overruns
					st_next.boot_cnt = CNT_ZERO;
					st_next.state = ACTIVE_CABLE ? UNASSIGNED_SOP
						: ASSIGN_SOP1;
				end
				else
				begin
					st_next.boot_cnt = st_reg.boot_cnt + CNT_ONE;
				end
			end
			UNASSIGNED_SOP:
			begin
				// Losing power wins over any assignment
				if (drop_power)
				begin
					st_next.state = CABLE_POWER_ON;
				end
				else if (vconn_local && !vconn_remote)
				begin
					st_next.state = ASSIGN_SOP1;
				end
				else if (vconn_remote && !vconn_local && SOP2_SUPPORT)
				begin
					st_next.state = ASSIGN_SOP2;
				end
				else
				begin
					st_next.state = UNASSIGNED_SOP;
				end
			end
			ASSIGN_SOP1:
			begin
				msg_ok = msg_to_sop1;
				if (drop_power)
				begin
					st_next.state = CABLE_POWER_ON;
				end
				else if (link_reset)
				begin
					st_next.state = ACTIVE_CABLE ? UNASSIGNED_SOP
						: CABLE_POWER_ON;
				end
			end
			ASSIGN_SOP2:
			begin
				msg_ok = msg_to_sop2;
				if (drop_power)
				begin
					st_next.state = CABLE_POWER_ON;
				end
				else if (link_reset)
				begin
					st_next.state = UNASSIGNED_SOP;
				end
			end
			default:
			begin
				st_next.state    = CABLE_POWER_ON;
				st_next.boot_cnt = CNT_ZERO;
			end
		endcase
		// Early messages are dropped, never answered
		st_next.ack  = msg_valid & msg_ok;
		st_next.drop = msg_valid & ~msg_ok;
		// Full Ra only while booting or unpowered
		st_next.ra_en   = (st_next.state == CABLE_POWER_ON) | ~vconn_any;
		st_next.sop1_en = (st_next.state == ASSIGN_SOP1);
		st_next.sop2_en = (st_next.state == ASSIGN_SOP2);
	end

	// State register; Ra is on out of reset since nothing is powered yet
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg.state    <= CABLE_POWER_ON;
			st_reg.boot_cnt <= CNT_ZERO;
			st_reg.ra_en    <= 1'b1;
			st_reg.sop1_en  <= 1'b0;
			st_reg.sop2_en  <= 1'b0;
			st_reg.ack      <= 1'b0;
			st_reg.drop     <= 1'b0;
		end
		else if (clk_en)
		begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flops
	assign msg_ack     = st_reg.ack;
	assign msg_drop    = st_reg.drop;
	assign ra_en       = st_reg.ra_en;
	assign sop1_en     = st_reg.sop1_en;
	assign sop2_en     = st_reg.sop2_en;
	assign cable_state = st_reg.state;

	// Checks on the marker behaviour
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_ra_unpowered: assert property (
		clk_en && !vconn_any |=> ra_en)
		else $error("Ra not presented without VCONN");

	a_boot_exit: assert property (
		clk_en && st_reg.state == CABLE_POWER_ON && vconn_any && boot_done
		|=> st_reg.state == (ACTIVE_CABLE ? UNASSIGNED_SOP : ASSIGN_SOP1))
		else $error("Boot complete but still in power on");

	a_boot_bound: assert property (
		st_reg.boot_cnt <= CNT_LAST)
		else $error("Boot timer ran past its limit");

	a_early_quiet: assert property (
		clk_en && msg_valid && (st_reg.state == CABLE_POWER_ON
		|| st_reg.state == UNASSIGNED_SOP) |=> !msg_ack && msg_drop)
		else $error("Message answered before assignment");

	a_local_assign: assert property (
		clk_en && st_reg.state == UNASSIGNED_SOP && !drop_power
		&& vconn_local && !vconn_remote |=> st_reg.state == ASSIGN_SOP1
		##0 sop1_en && !ra_en)
		else $error("Local VCONN did not assign SOP'");

	a_both_stay: assert property (
		clk_en && st_reg.state == UNASSIGNED_SOP && !drop_power
		&& vconn_local && vconn_remote |=> st_reg.state == UNASSIGNED_SOP)
		else $error("Left unassigned with VCONN on both plugs");

	a_sop1_answer: assert property (
		clk_en && st_reg.state == ASSIGN_SOP1 && msg_valid && msg_to_sop1
		|=> msg_ack && !msg_drop)
		else $error("SOP' message not answered");

	a_power_return: assert property (
		clk_en && st_reg.state == ASSIGN_SOP1 && drop_power
		|=> st_reg.state == CABLE_POWER_ON && ra_en)
		else $error("No return to power on after VCONN loss");

	a_passive_reset: assert property (
		clk_en && !ACTIVE_CABLE && st_reg.state == ASSIGN_SOP1
		&& !drop_power && link_reset |=> st_reg.state == CABLE_POWER_ON)
		else $error("Passive marker ignored link reset");

	a_active_reset: assert property (
		clk_en && ACTIVE_CABLE && (st_reg.state == ASSIGN_SOP1
		|| st_reg.state == ASSIGN_SOP2) && !drop_power && link_reset
		|=> st_reg.state == UNASSIGNED_SOP)
		else $error("Active marker ignored link reset");

	a_sop2_return: assert property (
		clk_en && st_reg.state == ASSIGN_SOP2 && drop_power
		|=> st_reg.state == CABLE_POWER_ON)
		else $error("SOP'' state kept after VCONN loss");

	a_sop2_answer: assert property (
		clk_en && st_reg.state == ASSIGN_SOP2 && msg_valid && msg_to_sop2
		|=> msg_ack && !msg_drop)
		else $error("SOP'' message not answered");

	a_unassigned_ra: assert property (
		clk_en && st_reg.state == UNASSIGNED_SOP && !drop_power
		&& vconn_any |=> !ra_en)
		else $error("Ra kept in unassigned state");

	a_passive_ra: assert property (
		clk_en && !ACTIVE_CABLE && st_reg.state == ASSIGN_SOP1
		&& !drop_power && !link_reset && vconn_any |=> !ra_en)
		else $error("Passive marker kept Ra after assignment");

	c_sop1_reached: cover property (
		st_reg.state == UNASSIGNED_SOP ##1 st_reg.state == ASSIGN_SOP1);

	c_sop2_reached: cover property (
		st_reg.state == UNASSIGNED_SOP ##1 st_reg.state == ASSIGN_SOP2);

	c_boot_timeout: cover property (
		clk_en && st_reg.state == CABLE_POWER_ON
		&& st_reg.boot_cnt == CNT_LAST && !boot_done);

	c_reset_return: cover property (
		st_reg.state == ASSIGN_SOP1 && link_reset && !drop_power);

endmodule
`default_nettype wire

/* File: dv/port_pd_model.sv */
`timescale 1ns/1ps
`default_nettype none
module port_pd_model
(
	// Clock and commands from the bench
	input  wire logic mclk,
	input  wire logic sup,
	input  wire logic early,
	input  wire logic req,
	input  wire logic to1,
	input  wire logic to2,
	// Address state of the marker
	input  wire logic sop1_en,
	input  wire logic sop2_en,
	// Lines into the marker
	output logic      vconn_out,
	output logic      msg_valid,
	output logic      msg_to_sop1,
	output logic      msg_to_sop2
);
	logic tgl = 1'b0;

	// Idle address lines wiggle so a stale value never looks valid
	always @(posedge mclk)
		tgl <= #1 ~tgl;

	// Hold messages back until an address is assigned, unless told
	assign msg_valid   = req & (early | sop1_en | sop2_en);
	assign msg_to_sop1 = msg_valid ? to1 : tgl;
	assign msg_to_sop2 = msg_valid ? to2 : ~tgl;
	assign vconn_out   = sup;
endmodule
`default_nettype wire

/* File: dv/test_cable_marker.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; \
	if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_cable_marker;
	import cable_marker_pkg::*;
	localparam int unsigned STB = 16;
	logic mclk = 0, rst_n = 0, clk_en = 1, rem = 0, low = 0, por = 0;
	logic sup = 0, early = 0, req = 0, to1 = 0, to2 = 0;
	logic boot = 0, hrst = 0, crst = 0;
	logic vloc, mv, m1, m2, ack, drop, ra, s1, s2, ra_p;
	cable_state_e st, st_p;
	int failures = 0;
	int tests_run = 0;

	// Free running clock, 25 ns period
	always #12.5 mclk = ~mclk;

	cable_marker #(.STABLE_CYCLES(STB)) u_cable_marker (
		.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
		.vconn_local_pin(vloc), .vconn_remote_pin(rem),
		.vconn_low_pin(low), .por_pin(por), .boot_done(boot),
		.hard_reset_seen(hrst), .cable_reset_seen(crst),
		.msg_valid(mv), .msg_to_sop1(m1), .msg_to_sop2(m2),
		.msg_ack(ack), .msg_drop(drop), .ra_en(ra),
		.sop1_en(s1), .sop2_en(s2), .cable_state(st));

	// Passive cable marker on the same pins, checked at a few points
	cable_marker #(.ACTIVE_CABLE(1'b0), .STABLE_CYCLES(STB))
		u_cable_marker_passive (
		.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
		.vconn_local_pin(vloc), .vconn_remote_pin(rem),
		.vconn_low_pin(low), .por_pin(por), .boot_done(boot),
		.hard_reset_seen(hrst), .cable_reset_seen(crst),
		.msg_valid(mv), .msg_to_sop1(m1), .msg_to_sop2(m2),
		.msg_ack(), .msg_drop(), .ra_en(ra_p),
		.sop1_en(), .sop2_en(), .cable_state(st_p));

	port_pd_model u_port_pd_model (
		.mclk(mclk), .sup(sup), .early(early), .req(req),
		.to1(to1), .to2(to2), .sop1_en(s1), .sop2_en(s2),
		.vconn_out(vloc), .msg_valid(mv), .msg_to_sop1(m1),
		.msg_to_sop2(m2));

	// Only an assigned address matching the message is answered
	function automatic logic exp_ack(cable_state_e s, logic a, logic b);
		return (s == ASSIGN_SOP1 && a) || (s == ASSIGN_SOP2 && b);
	endfunction

	task automatic step;
		@(posedge mclk);
		#1;
	endtask

	// Bounded wait, the pins pass a synchroniser first
	task automatic wt(input cable_state_e e);
		int i;
		i = 0;
		while (st !== e && i < 40)
		begin
			step;
			i++;
		end
		`CHK("state", e, st)
	endtask

	// One message in a known state; the answer stands one cycle only
	task automatic send(input cable_state_e s, input logic a,
		input logic b);
		logic x;
		logic v;
		req = 1;
		to1 = a;
		to2 = b;
		// Let the model's valid settle before reading it
		#1;
		v = mv;
		x = exp_ack(s, a, b) & v;
		step;
		`CHK("ack", x, ack)
		`CHK("drop", ~x & v, drop)
		req = 0;
		step;
		`CHK("answer end", 1'b0, ack | drop)
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog, far beyond the 150 or so cycles needed
	initial
	begin
		repeat (5000) @(posedge mclk);
		failures++;
		complete_run;
	end

	initial
	begin
		void'($urandom(55415));
		repeat (6) @(posedge mclk);
		#1 rst_n = 1;
		`CHK("state", CABLE_POWER_ON, st)
		`CHK("ra", 1'b1, ra)
		sup = 1;
		rem = 1;
		early = 1;
		repeat (4) step;
		`CHK("ra", 1'b1, ra)
		send(CABLE_POWER_ON, 1, 1);
		boot = 1;
		step;
		boot = 0;
		`CHK("state", UNASSIGNED_SOP, st)
		`CHK("state passive", ASSIGN_SOP1, st_p)
		`CHK("ra passive", 1'b0, ra_p)
		repeat (4) step;
		`CHK("state", UNASSIGNED_SOP, st)
		`CHK("ra", 1'b0, ra)
		send(UNASSIGNED_SOP, 1, 0);
		send(UNASSIGNED_SOP, 0, 1);
		rem = 0;
		wt(ASSIGN_SOP1);
		`CHK("sop1", 1'b1, s1)
		$display("test boot and assign done");
		early = 0;
		repeat (40) send(ASSIGN_SOP1, 1'($urandom), 1'($urandom));
		hrst = 1;
		step;
		hrst = 0;
		`CHK("state", UNASSIGNED_SOP, st)
		`CHK("state passive", CABLE_POWER_ON, st_p)
		wt(ASSIGN_SOP1);
		crst = 1;
		step;
		crst = 0;
		`CHK("state", UNASSIGNED_SOP, st)
		wt(ASSIGN_SOP1);
		$display("test messages and resets done");
		low = 1;
		repeat (3) step;
		`CHK("state", CABLE_POWER_ON, st)
		low = 0;
		repeat (STB - 1) step;
		`CHK("state", CABLE_POWER_ON, st)
		repeat (5) step;
		`CHK("boot bound", ASSIGN_SOP1, st)
		sup = 0;
		rem = 1;
		por = 1;
		repeat (3) step;
		`CHK("state", CABLE_POWER_ON, st)
		por = 0;
		repeat (3) step;
		boot = 1;
		step;
		boot = 0;
		wt(ASSIGN_SOP2);
		`CHK("ra", 1'b0, ra)
		`CHK("ra passive", 1'b1, ra_p)
		`CHK("state passive", CABLE_POWER_ON, st_p)
		send(ASSIGN_SOP2, 0, 1);
		send(ASSIGN_SOP2, 1, 0);
		clk_en = 0;
		hrst = 1;
		repeat (2) step;
		hrst = 0;
		`CHK("frozen", ASSIGN_SOP2, st)
		clk_en = 1;
		step;
		hrst = 1;
		step;
		hrst = 0;
		`CHK("state", UNASSIGNED_SOP, st)
		wt(ASSIGN_SOP2);
		low = 1;
		repeat (3) step;
		`CHK("state", CABLE_POWER_ON, st)
		$display("test remote plug done");
		complete_run;
	end
endmodule
`default_nettype wire
